/* shared/fspmc_pkg.sv */
// Behaviour
// - speed set by pwm duty cycle
// - fixed three speed or analog proportional modes
// - analog input maps linearly between min and max
// - fan runs only while run request asserted
// - run mode without error flashes led
// - program timeout flashes led, reset clears
// - run mode error holds led on
// - reset clears error once condition gone
// - program mode not timed out, led on
// - internal fault leaves led off
// - program mode holds motor stopped
// - program timeout after about five and a half minutes
// - switch 8 store saves adjusted setting
// - monitor level presented only in program mode
// - switch 2 selects analog or fixed speed
// - switch 3 adjusts high or max setting
package fspmc_pkg;
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned TIMEOUT_S      = 330;
	localparam int unsigned STORE_HOLD_MS  = 500;
	localparam int unsigned FLASH_HALF_MS  = 500;
	localparam longint unsigned TIMEOUT_CYC = longint'(TIMEOUT_S) * CLK_HZ;
	localparam int unsigned STORE_HOLD_CYC = STORE_HOLD_MS * (CLK_HZ / 1000);
	localparam int unsigned FLASH_HALF_CYC = FLASH_HALF_MS * (CLK_HZ / 1000);
	localparam int unsigned SPD_W          = 8;
	// switch positions, index 0 is switch 1
	localparam int unsigned SW_PROG  = 0;
	localparam int unsigned SW_ANLG  = 1;
	localparam int unsigned SW_HI    = 2;
	localparam int unsigned SW_MED   = 3;
	localparam int unsigned SW_LO    = 4;
	localparam int unsigned SW_STORE = 7;
	// reset values of retained settings
	localparam logic [7:0] RST_HI  = 8'hE0;
	localparam logic [7:0] RST_MED = 8'hA0;
	localparam logic [7:0] RST_LO  = 8'h60;
	localparam logic [7:0] RST_MAX = 8'hFF;
	localparam logic [7:0] RST_MIN = 8'h40;
	// axi-lite offsets
	localparam logic [7:0] A_CTRL  = 8'h00;
	localparam logic [7:0] A_STAT  = 8'h04;
	localparam logic [7:0] A_IRQ   = 8'h08;
	localparam logic [7:0] A_MASK  = 8'h0C;
	localparam logic [7:0] A_SPEED = 8'h10;
	localparam int unsigned IRQ_STORE = 0;
	localparam int unsigned IRQ_TOUT  = 1;
	localparam int unsigned IRQ_ERR   = 2;
	typedef enum logic [1:0] {
		FSPMC_RUN   = 2'b00,
		FSPMC_ERR   = 2'b01,
		FSPMC_PROG  = 2'b10,
		FSPMC_TOUT  = 2'b11
	} fspmc_state_t;
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] med;
		logic [7:0] lo;
		logic [7:0] max;
		logic [7:0] min;
	} fspmc_set_t;
endpackage

/* hdl/fspmc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fspmc_top #(
	parameter longint unsigned TIMEOUT_CYC    = fspmc_pkg::TIMEOUT_CYC,
	parameter int unsigned     STORE_HOLD_CYC = fspmc_pkg::STORE_HOLD_CYC,
	parameter int unsigned     FLASH_HALF_CYC = fspmc_pkg::FLASH_HALF_CYC
) (
	input  wire logic        aclk,          // 25 MHz clock
	input  wire logic        aresetn,       // sync reset, low active
	input  wire logic [7:0]  cfg_sw,        // config switches, bit0 = switch 1
	input  wire logic        reset_btn,     // reset button, high pressed
	input  wire logic        run_req,       // fan run request
	input  wire logic [7:0]  pot_level,     // speed potentiometer sample
	input  wire logic [7:0]  remote_level,  // remote analog sample, 0 = 2 V
	input  wire logic [1:0]  speed_sel,     // fixed speed: 0 off 1 lo 2 med 3 hi
	input  wire logic        sys_error,     // system error condition
	input  wire logic        int_fault,     // internal fault
	output logic             pwm_out,       // motor pwm command
	output logic             status_led,    // status led, high lit
	output logic [7:0]       monitor_point_high, // monitor level, + point
	output logic [7:0]       monitor_point_low,  // monitor reference, - point
	output logic             irq,           // level interrupt
	input  wire logic [7:0]  s_axi_awaddr,  // write address
	input  wire logic        s_axi_awvalid, // write address valid
	output logic             s_axi_awready, // write address ready
	input  wire logic [31:0] s_axi_wdata,   // write data
	input  wire logic [3:0]  s_axi_wstrb,   // write strobes
	input  wire logic        s_axi_wvalid,  // write data valid
	output logic             s_axi_wready,  // write data ready
	output logic [1:0]       s_axi_bresp,   // write response
	output logic             s_axi_bvalid,  // write response valid
	input  wire logic        s_axi_bready,  // write response ready
	input  wire logic [7:0]  s_axi_araddr,  // read address
	input  wire logic        s_axi_arvalid, // read address valid
	output logic             s_axi_arready, // read address ready
	output logic [31:0]      s_axi_rdata,   // read data
	output logic [1:0]       s_axi_rresp,   // read response
	output logic             s_axi_rvalid,  // read valid
	input  wire logic        s_axi_rready   // read ready
);
	// two-stage synchronisers for all pin inputs
	// switches, button and analog samples all come from outside aclk;
	// nothing but sync_ff reads meta_ff
	// analog samples are not gray coded, so a word caught mid-change
	// may mix old and new bits for one cycle; the fan tolerates that
	logic [28:0] meta_ff;
	logic [28:0] sync_ff;
	always_ff @(posedge aclk) begin
		meta_ff <= {cfg_sw, reset_btn, run_req, pot_level, speed_sel, sys_error,
			int_fault, remote_level[7:1]};
		sync_ff <= meta_ff;
	end
	// remote lsb synchronised on its own pair of flops
	logic       rmt_lsb_m_ff;
	logic       rmt_lsb_ff;
	always_ff @(posedge aclk) begin
		rmt_lsb_m_ff <= remote_level[0];
		rmt_lsb_ff   <= rmt_lsb_m_ff;
	end
	// synchronised views of the pins
	wire [7:0] sw_s    = sync_ff[28:21];
	wire       btn_s   = sync_ff[20];
	wire       run_s   = sync_ff[19];
	wire [7:0] pot_s   = sync_ff[18:11];
	wire [1:0] sel_s   = sync_ff[10:9];
	wire       err_s   = sync_ff[8];
	wire       fault_s = sync_ff[7];
	wire [7:0] rmt_s   = {sync_ff[6:0], rmt_lsb_ff};

	// button edge
	// delay flop resets to the idle level, so no false press follows reset
	logic btn_d_ff;
	always_ff @(posedge aclk) begin
		btn_d_ff <= aresetn ? btn_s : 1'b0;
	end
	wire btn_press = btn_s & ~btn_d_ff;

	// software control register: bit0 soft fault, bit1 soft reset press
	// a soft press acts exactly like the reset button
	logic [1:0] ctrl_ff;
	wire        sw_fault = ctrl_ff[0];
	wire        press    = btn_press | ctrl_ff[1];
	wire        prog     = sw_s[fspmc_pkg::SW_PROG];
	wire        fault    = fault_s | sw_fault;

	// mode state machine
	// run:  fan may spin, led flashes
	// err:  system error seen in run, led steady, fan stopped
	// prog: program switch on, led steady, fan stopped
	// tout: program session idle too long, led flashes
	// leaving program mode always returns to run; a live error
	// then takes it straight back to err
	fspmc_pkg::fspmc_state_t st_ff;
	fspmc_pkg::fspmc_state_t nxt_st;
	logic [38:0] tout_cnt_ff;
	wire         tout_hit = (tout_cnt_ff >= 39'(TIMEOUT_CYC - 1));
	always_comb begin
		nxt_st = st_ff;
		unique case (st_ff)
			fspmc_pkg::FSPMC_RUN: begin
				if (prog)
					nxt_st = fspmc_pkg::FSPMC_PROG;
				else if (err_s)
					nxt_st = fspmc_pkg::FSPMC_ERR;
			end
			fspmc_pkg::FSPMC_ERR: begin
				if (prog)
					nxt_st = fspmc_pkg::FSPMC_PROG;
				else if (press && !err_s)
					nxt_st = fspmc_pkg::FSPMC_RUN;
			end
			fspmc_pkg::FSPMC_PROG: begin
				if (!prog)
					nxt_st = fspmc_pkg::FSPMC_RUN;
				else if (tout_hit && !press)
					nxt_st = fspmc_pkg::FSPMC_TOUT;
			end
			fspmc_pkg::FSPMC_TOUT: begin
				if (!prog)
					nxt_st = fspmc_pkg::FSPMC_RUN;
				else if (press)
					nxt_st = fspmc_pkg::FSPMC_PROG;
			end
		endcase
	end
	// timeout counts program time since entry or last press
	// the counter saturates, so a very long session cannot wrap back
	// 39 bits hold the default of several minutes of aclk cycles
	always_ff @(posedge aclk) begin
		if (!aresetn || st_ff != fspmc_pkg::FSPMC_PROG || press)
			tout_cnt_ff <= '0;
		else if (!tout_hit)
			tout_cnt_ff <= tout_cnt_ff + 39'h1;
	end
	// state register, back to run on reset
	always_ff @(posedge aclk) begin
		st_ff <= aresetn ? nxt_st : fspmc_pkg::FSPMC_RUN;
	end

	// store: switch 8 held on then released commits the pot value
	// the hold counter saturates once the minimum hold is reached;
	// a short flick of switch 8 therefore stores nothing
	// outside program mode switch 8 is ignored
	logic [31:0] hold_cnt_ff;
	logic        sw8_d_ff;
	wire         sw8      = sw_s[fspmc_pkg::SW_STORE];
	wire         held     = (hold_cnt_ff >= 32'(STORE_HOLD_CYC));
	wire         editable = (st_ff == fspmc_pkg::FSPMC_PROG) | (st_ff == fspmc_pkg::FSPMC_TOUT);
	wire         store    = sw8_d_ff & ~sw8 & held & editable;
	always_ff @(posedge aclk) begin
		sw8_d_ff <= aresetn ? sw8 : 1'b0;
		if (!aresetn || !sw8)
			hold_cnt_ff <= '0;
		else if (!held)
			hold_cnt_ff <= hold_cnt_ff + 32'h1;
	end

	// retained settings; analog selects max/min, fixed selects hi/med/lo
	// switch 3 picks hi or max, switch 5 lo or min, switch 4 med in
	// fixed mode only; with no select switch on, a store changes nothing
	// values live in flops: they survive a timeout but not aresetn
	fspmc_pkg::fspmc_set_t set_ff;
	wire anlg = sw_s[fspmc_pkg::SW_ANLG];
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			set_ff <= {fspmc_pkg::RST_HI, fspmc_pkg::RST_MED, fspmc_pkg::RST_LO,
				fspmc_pkg::RST_MAX, fspmc_pkg::RST_MIN};
		end else if (store) begin
			if (sw_s[fspmc_pkg::SW_HI] && anlg)
				set_ff.max <= pot_s;
			else if (sw_s[fspmc_pkg::SW_HI])
				set_ff.hi <= pot_s;
			else if (sw_s[fspmc_pkg::SW_MED] && !anlg)
				set_ff.med <= pot_s;
			else if (sw_s[fspmc_pkg::SW_LO] && anlg)
				set_ff.min <= pot_s;
			else if (sw_s[fspmc_pkg::SW_LO])
				set_ff.lo <= pot_s;
		end
	end

	// linear map min + (max-min)*level/255, clamped if min > max
	// level 0 is the bottom of the remote range and gives min,
	// level 255 the top and gives max; the division is exact at both
	// ends, which is where the speed range must land
	function automatic logic [7:0] fspmc_map(input logic [7:0] lo, input logic [7:0] hi,
		input logic [7:0] lvl);
		logic [15:0] prod;
		prod = 16'(hi - lo) * 16'(lvl);
		if (hi <= lo)
			return lo;
		return 8'(lo + 8'(prod / 16'h00FF));
	endfunction
	// fixed speed from the selector, code 0 means off
	wire [7:0] fix_spd = (sel_s == 2'h3) ? set_ff.hi :
		(sel_s == 2'h2) ? set_ff.med :
		(sel_s == 2'h1) ? set_ff.lo : 8'h00;
	wire [7:0] anl_spd = fspmc_map(set_ff.min, set_ff.max, rmt_s);
	// fan runs only in run state with a run request and no fault
	wire       run_ok  = run_s & ~prog & ~fault & (st_ff == fspmc_pkg::FSPMC_RUN);
	wire [7:0] cmd_spd = !run_ok ? 8'h00 : (anlg ? anl_spd : fix_spd);

	// pwm: 255-step period, duty = cmd_spd / 255
	// duty 0 is always off, duty 255 always on
	logic [7:0] pwm_cnt_ff;
	logic [7:0] duty_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwm_cnt_ff <= '0;
			duty_ff    <= '0;
			pwm_out    <= 1'b0;
		end else begin
			pwm_cnt_ff <= (pwm_cnt_ff == 8'hFE) ? 8'h00 : pwm_cnt_ff + 8'h01;
			// speed changes wait for the period end, a stop acts at once
			if (pwm_cnt_ff == 8'hFE || !run_ok)
				duty_ff <= cmd_spd;
			pwm_out <= run_ok & (pwm_cnt_ff < duty_ff);
		end
	end

	// led flash timebase
	// one toggle per half period; the default gives about one hertz
	logic [31:0] flash_cnt_ff;
	logic        flash_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || flash_cnt_ff >= 32'(FLASH_HALF_CYC - 1))
			flash_cnt_ff <= '0;
		else
			flash_cnt_ff <= flash_cnt_ff + 32'h1;
		if (!aresetn)
			flash_ff <= 1'b0;
		else if (flash_cnt_ff >= 32'(FLASH_HALF_CYC - 1))
			flash_ff <= ~flash_ff;
	end
	// led priority: fault dark, then flashing states, else steady on
	wire led_nxt = fault ? 1'b0 :
		(st_ff == fspmc_pkg::FSPMC_RUN)  ? flash_ff :
		(st_ff == fspmc_pkg::FSPMC_TOUT) ? flash_ff :
		1'b1;

	// monitor points: level only in program mode
	// the low point is the reference and stays at zero
	wire [7:0] mon_nxt = !prog ? 8'h00 :
		sw_s[fspmc_pkg::SW_HI] ? pot_s : pot_s;
	always_ff @(posedge aclk) begin
		status_led         <= aresetn ? led_nxt : 1'b0;
		monitor_point_high <= aresetn ? mon_nxt : 8'h00;
		monitor_point_low  <= 8'h00;
	end

	// interrupt events: store, timeout entry, error entry
	// error and timeout events are one-cycle pulses taken from state transitions,
	// so a state held for long raises its bit only once
	// a mask bit of one lets its status bit drive irq
	logic [2:0] irq_ff;
	logic [2:0] mask_ff;
	wire [2:0]  ev = {(nxt_st == fspmc_pkg::FSPMC_ERR) & (st_ff != fspmc_pkg::FSPMC_ERR),
		(nxt_st == fspmc_pkg::FSPMC_TOUT) & (st_ff != fspmc_pkg::FSPMC_TOUT), store};
	assign irq = |(irq_ff & mask_ff);

	// axi-lite slave: takes aw and w in either order
	// each half is parked until both are in; each ready drops while its own half
	// or a response is pending, which keeps one write in flight
	// only the low byte lane carries writable bits
	logic       aw_ok_ff;
	logic       w_ok_ff;
	logic [7:0] awa_ff;
	logic [31:0] wd_ff;
	logic [3:0] ws_ff;
	// ready signals are combinational from the pending flags
	assign s_axi_awready = ~aw_ok_ff & ~s_axi_bvalid;
	assign s_axi_wready  = ~w_ok_ff & ~s_axi_bvalid;
	assign s_axi_arready = ~s_axi_rvalid;
	wire        wr_go = aw_ok_ff & w_ok_ff;
	wire        wr_hit = (awa_ff == fspmc_pkg::A_CTRL) | (awa_ff == fspmc_pkg::A_IRQ) |
		(awa_ff == fspmc_pkg::A_MASK);
	wire        wr_irq  = wr_go & ws_ff[0] & (awa_ff == fspmc_pkg::A_IRQ);
	wire [2:0]  irq_clr = wr_irq ? wd_ff[2:0] : 3'h0;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ok_ff     <= 1'b0;
			w_ok_ff      <= 1'b0;
			awa_ff       <= '0;
			wd_ff        <= '0;
			ws_ff        <= '0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			ctrl_ff      <= '0;
			mask_ff      <= '0;
			irq_ff       <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_ff <= 1'b1;
				awa_ff   <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_ff <= 1'b1;
				wd_ff   <= s_axi_wdata;
				ws_ff   <= s_axi_wstrb;
			end
			ctrl_ff[1] <= 1'b0; // soft press is a one-cycle pulse
			if (wr_go) begin
				aw_ok_ff     <= 1'b0;
				w_ok_ff      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
				if (ws_ff[0] && awa_ff == fspmc_pkg::A_CTRL)
					ctrl_ff <= wd_ff[1:0];
				if (ws_ff[0] && awa_ff == fspmc_pkg::A_MASK)
					mask_ff <= wd_ff[2:0];
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			irq_ff <= (irq_ff & ~irq_clr) | ev; // set wins over clear
		end
	end

	// read path
	// reads have no side effects; the address is decoded combinationally
	// and the data registered together with rvalid
	wire [31:0] rd_mux = (s_axi_araddr == fspmc_pkg::A_CTRL)  ? {31'h0, ctrl_ff[0]} :
		(s_axi_araddr == fspmc_pkg::A_STAT)  ? {24'h0, run_ok, fault, prog, anlg,
			status_led, pwm_out, st_ff} :
		(s_axi_araddr == fspmc_pkg::A_IRQ)   ? {29'h0, irq_ff} :
		(s_axi_araddr == fspmc_pkg::A_MASK)  ? {29'h0, mask_ff} :
		(s_axi_araddr == fspmc_pkg::A_SPEED) ? {24'h0, duty_ff} : 32'h0;
	// unmapped reads answer slverr with zero data
	wire rd_hit = (s_axi_araddr == fspmc_pkg::A_CTRL) | (s_axi_araddr == fspmc_pkg::A_STAT) |
		(s_axi_araddr == fspmc_pkg::A_IRQ) | (s_axi_araddr == fspmc_pkg::A_MASK) |
		(s_axi_araddr == fspmc_pkg::A_SPEED);
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= 2'h0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // fspmc_top
`default_nettype wire

/* testbench/fspmc_top_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module fspmc_top_monitor (
	input wire logic        aclk,               // clock
	input wire logic        aresetn,            // sync reset, low active
	input wire logic [7:0]  cfg_sw,             // switches
	input wire logic        run_req,            // run request
	input wire logic        int_fault,          // internal fault
	input wire logic        pwm_out,            // motor command
	input wire logic        status_led,         // status led
	input wire logic [7:0]  monitor_point_high, // monitor level
	input wire logic [7:0]  monitor_point_low,  // monitor reference
	input wire logic        s_axi_awvalid,      // aw valid
	input wire logic        s_axi_awready,      // aw ready
	input wire logic        s_axi_wvalid,       // w valid
	input wire logic        s_axi_wready,       // w ready
	input wire logic        s_axi_bvalid,       // b valid
	input wire logic        s_axi_bready,       // b ready
	input wire logic        s_axi_rvalid,       // r valid
	input wire logic        s_axi_rready,       // r ready
	input wire logic [31:0] s_axi_rdata         // read data
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// pins pass a two stage sync, so eight cycles of settle are allowed
	property p_prog_stop; cfg_sw[0] [*8] |-> !pwm_out; endproperty
	a_prog_stop: assert property (p_prog_stop) else $error("pwm in program mode");
	property p_run_stop; !run_req [*8] |-> !pwm_out; endproperty
	a_run_stop: assert property (p_run_stop) else $error("pwm without run request");
	property p_fault_led; int_fault [*8] |-> !status_led; endproperty
	a_fault_led: assert property (p_fault_led) else $error("led lit under fault");
	property p_mon_zero; !cfg_sw[0] [*8] |-> monitor_point_high == 8'h00; endproperty
	a_mon_zero: assert property (p_mon_zero) else $error("monitor level in run mode");
	property p_mon_low; monitor_point_low == 8'h00; endproperty
	a_mon_low: assert property (p_mon_low) else $error("monitor reference not zero");
	// a response must stand until the master takes it
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_b_after;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_b_after: assert property (p_b_after) else $error("write response late");
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
	c_flash: cover property ($rose(status_led));
endmodule // fspmc_top_monitor
bind fspmc_top fspmc_top_monitor u_mon (.*);
`default_nettype wire

/* testbench/fspmc_fan_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fspmc_fan_model (
	input wire logic  aclk,    // clock
	input wire logic  aresetn, // sync reset, low active
	input wire logic  pwm_in,  // speed command
	output logic [7:0] duty    // high clocks of the last window
);
	logic [7:0] ph_ff;
	logic [7:0] acc_ff;
	// any 255 clock window of a 255 clock period holds the whole duty
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ph_ff <= 8'h00;
			acc_ff <= 8'h00;
			duty <= 8'h00;
		end else if (ph_ff == 8'hFE) begin
			ph_ff <= 8'h00;
			acc_ff <= 8'h00;
			duty <= acc_ff + 8'(pwm_in);
		end else begin
			ph_ff <= ph_ff + 8'h01;
			acc_ff <= acc_ff + 8'(pwm_in);
		end
	end
endmodule // fspmc_fan_model
`default_nettype wire

/* testbench/fan_speed_pwm_mode_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module fan_speed_pwm_mode_control_tb_top;
	logic        aclk = 1'b0, aresetn = 1'b0, reset_btn = 1'b0, run_req = 1'b0;
	logic        sys_error = 1'b0, int_fault = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
	logic        arvalid = 1'b0, pwm_out, status_led, irq, awready, wready, bvalid;
	logic        arready, rvalid, bready = 1'b0, rready = 1'b0;
	logic [7:0]  cfg_sw = 8'h00, pot_level = 8'h00, remote_level = 8'h00;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, mph, mpl, duty;
	logic [1:0]  speed_sel = 2'h0, bresp, rresp, resp;
	logic [31:0] wdata = 32'h0, rdata, v;
	logic [7:0]  fx [0:3] = '{8'h00, fspmc_pkg::RST_LO, fspmc_pkg::RST_MED, fspmc_pkg::RST_HI};
	int          n_errors = 0, tests_run = 0;
	initial forever #20 aclk = ~aclk;
	fspmc_top #(.TIMEOUT_CYC(200), .STORE_HOLD_CYC(10), .FLASH_HALF_CYC(8)) u_dut (
		.aclk(aclk), .aresetn(aresetn), .cfg_sw(cfg_sw), .reset_btn(reset_btn),
		.run_req(run_req), .pot_level(pot_level), .remote_level(remote_level),
		.speed_sel(speed_sel), .sys_error(sys_error), .int_fault(int_fault),
		.pwm_out(pwm_out), .status_led(status_led), .monitor_point_high(mph),
		.monitor_point_low(mpl), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	fspmc_fan_model u_fan (.aclk(aclk), .aresetn(aresetn), .pwm_in(pwm_out), .duty(duty));
	task automatic report_and_stop;
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// ready and response sampled at the edge; bready and rready rise one
	// edge after the response shows, so a waiting response is exercised
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid === 1'b1 && !bready)
				bready <= 1'b1;
		end while (bready !== 1'b1 || bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
			if (rvalid === 1'b1 && !rready)
				rready <= 1'b1;
		end while (rready !== 1'b1 || rvalid !== 1'b1);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask
	task automatic rck(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a);
		chk(v & m, e);
	endtask
	// sync, one pwm period to take the duty, then up to two fan windows
	task automatic dchk(input logic [7:0] e);
		cyc(800);
		chk(duty, e);
	endtask
	task automatic press;
		reset_btn <= 1'b1;
		cyc(4);
		reset_btn <= 1'b0;
		cyc(6);
	endtask
	// forty cycles is more than two flash halves, so a flash would show
	task automatic hold_chk(input logic e);
		bit bad;
		bad = 1'b0;
		repeat (40) begin
			@(posedge aclk);
			if (status_led !== e)
				bad = 1'b1;
		end
		chk(bad, 1'b0);
	endtask
	task automatic flash_chk;
		int n;
		for (int i = 0; i < 2; i++) begin
			n = 0;
			v[0] = status_led;
			while (status_led === v[0] && n < 100) begin
				@(posedge aclk);
				n++;
			end
		end
		chk(n, 8);
	endtask
	initial begin
		cyc(20000);
		n_errors++;
		report_and_stop();
	end
	initial begin
		cyc(6);
		aresetn <= 1'b1;
		cyc(4);
		rck(fspmc_pkg::A_STAT, 32'h3, 32'h0);
		rd(8'h20);
		chk(v, 32'h0);
		chk(resp, 2'h2);
		wr(fspmc_pkg::A_MASK, 32'h7);
		wr(fspmc_pkg::A_IRQ, 32'h7);
		chk(resp, 2'h0);
		run_req <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			speed_sel <= 2'(s);
			dchk(fx[s]);
		end
		rck(fspmc_pkg::A_SPEED, 32'hFF, fspmc_pkg::RST_HI);
		run_req <= 1'b0;
		dchk(8'h00);
		flash_chk();
		$display("fixed speed test done");
		cfg_sw <= 8'h02;
		run_req <= 1'b1;
		dchk(fspmc_pkg::RST_MIN);
		remote_level <= 8'hFF;
		dchk(fspmc_pkg::RST_MAX);
		cfg_sw <= 8'h00;
		$display("analog test done");
		sys_error <= 1'b1;
		cyc(10);
		rck(fspmc_pkg::A_STAT, 32'h3, 32'h1);
		hold_chk(1'b1);
		chk(irq, 1'b1);
		wr(fspmc_pkg::A_MASK, 32'h3);
		cyc(2);
		chk(irq, 1'b0);
		wr(fspmc_pkg::A_MASK, 32'h0);
		wr(fspmc_pkg::A_IRQ, 32'h4);
		rck(fspmc_pkg::A_IRQ, 32'h7, 32'h0);
		press();
		rck(fspmc_pkg::A_STAT, 32'h3, 32'h1);
		sys_error <= 1'b0;
		press();
		rck(fspmc_pkg::A_STAT, 32'h3, 32'h0);
		$display("error test done");
		cfg_sw <= 8'h05;
		pot_level <= 8'h80;
		cyc(10);
		press();
		rck(fspmc_pkg::A_STAT, 32'h3, 32'h2);
		hold_chk(1'b1);
		chk(mph, 8'h80);
		chk(mpl, 8'h00);
		cfg_sw <= 8'h85;
		cyc(15);
		cfg_sw <= 8'h05;
		cyc(6);
		rck(fspmc_pkg::A_IRQ, 32'h1, 32'h1);
		cyc(50);
		rck(fspmc_pkg::A_STAT, 32'h3, 32'h2);
		cyc(110);
		rck(fspmc_pkg::A_STAT, 32'h3, 32'h3);
		flash_chk();
		dchk(8'h00);
		press();
		rck(fspmc_pkg::A_STAT, 32'h3, 32'h2);
		cfg_sw <= 8'h00;
		dchk(8'h80);
		chk(mph, 8'h00);
		$display("program test done");
		int_fault <= 1'b1;
		cyc(10);
		hold_chk(1'b0);
		dchk(8'h00);
		$display("fault test done");
		report_and_stop();
	end
endmodule // fan_speed_pwm_mode_control_tb_top
`default_nettype wire
